// file: common/cpi_defines.svh
// Offsets, field positions and timing counts of the channel process image.
// Assumes inclusion by bare name from package and design files.
`ifndef CPI_DEFINES_SVH
`define CPI_DEFINES_SVH
`define CPI_NUM_CH 8
`define CPI_COMPLEX_BYTES 24
`define CPI_COMPACT_BYTES 16
// Widest image: aligned complex layout, eight channels of four bytes
`define CPI_IMAGE_BYTES 32
`define CPI_UNALIGNED_STRIDE 3
`define CPI_ALIGNED_STRIDE 4
`define CPI_CB_REGACC 7
`define CPI_CB_RW 6
`define CPI_CB_CALI 5
`define CPI_CB_GAIN 4
`define CPI_CB_OFFSET 3
`define CPI_CB_CLOCK 2
`define CPI_CB_UP 1
`define CPI_CB_DOWN 0
`define CPI_SB_REGACC 7
`define CPI_SB_ERROR 6
`define CPI_SB_OVER 1
`define CPI_SB_UNDER 0
`define CPI_UNLOCK_REG 6'h1f
`define CPI_UNLOCK_CODE 16'h1235
`define CPI_SLOW_NS 10000
`define CPI_FAST_NS 1000
`define CPI_CLK_NS 10
`define CPI_SLOW_CYC (`CPI_SLOW_NS / `CPI_CLK_NS)
`define CPI_FAST_CYC (`CPI_FAST_NS / `CPI_CLK_NS)
`endif

// file: common/cpi_pkg.sv
// Types shared by the process image port and its channel logic.
// Assumes cpi_defines.svh is on the include path.
`include "cpi_defines.svh"
package cpi_pkg;
  typedef logic [7:0] cpi_byte_t;
  typedef logic [15:0] cpi_word_t;
  typedef enum logic [1:0] {
    CPI_MODE_PROC = 2'b01,
    CPI_MODE_REG = 2'b10
  } cpi_mode_t;
endpackage

// file: hw/cpi_channel.sv
// One channel: control byte decode, calibration trim, status byte.
// Assumes the control byte and output word are synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "cpi_defines.svh"
module cpi_channel
  import cpi_pkg::*;
#(
  parameter int SLOW_CYC = `CPI_SLOW_CYC,
  parameter int FAST_CYC = `CPI_FAST_CYC
) (
  input wire logic clock_i, // System clock
  input wire logic rst_i, // Async reset, high
  input wire cpi_pkg::cpi_byte_t channel_control_byte_i, // Control byte
  input wire cpi_pkg::cpi_word_t channel_output_word_i, // Output word
  input wire cpi_pkg::cpi_word_t sample_i, // Raw measured value
  input wire logic over_i, // Value too large
  input wire logic under_i, // Value too small
  input wire logic fault_i, // Channel fault
  output cpi_pkg::cpi_byte_t channel_status_byte_o, // Status byte
  output cpi_pkg::cpi_word_t channel_input_word_o, // Input word
  output logic nv_commit_o, // Store trim permanently
  output cpi_pkg::cpi_word_t gain_trim_o, // Gain trim value
  output cpi_pkg::cpi_word_t offset_trim_o // Offset trim value
);
  import cpi_pkg::*;

  cpi_byte_t status_q, status_d;
  cpi_word_t data_q, data_d;
  cpi_word_t gain_q, gain_d, offs_q, offs_d;
  logic unlock_q, unlock_d, commit_q, commit_d;
  logic [15:0] tick_q, tick_d;
  cpi_mode_t mode;
  logic regacc, cal_ok, step;

  always_comb begin
    regacc = channel_control_byte_i[`CPI_CB_REGACC];
    mode = regacc ? CPI_MODE_REG : CPI_MODE_PROC;
    cal_ok = (mode == CPI_MODE_PROC) && unlock_q
      && channel_control_byte_i[`CPI_CB_CALI];
    step = (tick_q == 16'h0000);
    tick_d = tick_q;
    if (!cal_ok || step) begin
      tick_d = channel_control_byte_i[`CPI_CB_CLOCK]
        ? 16'(FAST_CYC - 1) : 16'(SLOW_CYC - 1);
    end else begin
      tick_d = tick_q - 16'h0001;
    end
    gain_d = gain_q;
    offs_d = offs_q;
    if (cal_ok && step) begin
      if (channel_control_byte_i[`CPI_CB_GAIN]) begin
        if (channel_control_byte_i[`CPI_CB_UP]) gain_d = gain_q + 16'h0001;
        else if (channel_control_byte_i[`CPI_CB_DOWN])
          gain_d = gain_q - 16'h0001;
      end
      if (channel_control_byte_i[`CPI_CB_OFFSET]) begin
        if (channel_control_byte_i[`CPI_CB_UP]) offs_d = offs_q + 16'h0001;
        else if (channel_control_byte_i[`CPI_CB_DOWN])
          offs_d = offs_q - 16'h0001;
      end
    end
    // Writes to the unlock register come only by register communication
    unlock_d = unlock_q;
    commit_d = 1'b0;
    if (regacc && channel_control_byte_i[`CPI_CB_RW]
        && channel_control_byte_i[5:0] == `CPI_UNLOCK_REG) begin
      unlock_d = (channel_output_word_i == `CPI_UNLOCK_CODE);
      commit_d = unlock_q && (channel_output_word_i == 16'h0000);
    end
    if (mode == CPI_MODE_REG) begin
      status_d = {1'b1, 1'b0, channel_control_byte_i[5:0]};
      data_d = (channel_control_byte_i[5:0] == `CPI_UNLOCK_REG)
        ? {15'h0000, unlock_q} : 16'h0000;
    end else begin
      status_d = 8'h00;
      status_d[`CPI_SB_ERROR] = fault_i | over_i | under_i;
      status_d[`CPI_SB_OVER] = over_i;
      status_d[`CPI_SB_UNDER] = under_i;
      data_d = sample_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= 8'h00;
      data_q <= 16'h0000;
      gain_q <= 16'h0000;
      offs_q <= 16'h0000;
      unlock_q <= 1'b0;
      commit_q <= 1'b0;
      tick_q <= 16'h0000;
    end else begin
      status_q <= status_d;
      data_q <= data_d;
      gain_q <= gain_d;
      offs_q <= offs_d;
      unlock_q <= unlock_d;
      commit_q <= commit_d;
      tick_q <= tick_d;
    end
  end

  assign channel_status_byte_o = status_q;
  assign channel_input_word_o = data_q;
  assign nv_commit_o = commit_q;
  assign gain_trim_o = gain_q;
  assign offset_trim_o = offs_q;

  proc_ack_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !channel_control_byte_i[`CPI_CB_REGACC] |=> !status_q[`CPI_SB_REGACC])
    else $error("status bit 7 set in process data mode");
  reg_ack_a: assert property (@(posedge clock_i) disable iff (rst_i)
    channel_control_byte_i[`CPI_CB_REGACC]
      |=> status_q[7:6] == 2'b10
        && status_q[5:0] == $past(channel_control_byte_i[5:0]))
    else $error("register access not acknowledged");
  over_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (!regacc && over_i) |=> status_q[`CPI_SB_OVER] && status_q[`CPI_SB_ERROR])
    else $error("overrange not reported");
  under_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (!regacc && under_i) |=> status_q[`CPI_SB_UNDER])
    else $error("underrange not reported");
  reserved_zero_a: assert property (@(posedge clock_i)
    disable iff (rst_i) !regacc |=> status_q[5:2] == 4'h0)
    else $error("reserved status bits not zero");
  locked_trim_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !unlock_q |=> $stable(gain_q) && $stable(offs_q))
    else $error("trim changed while locked");
  proc_data_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !regacc |=> data_q == $past(sample_i))
    else $error("input word not process value");
  commit_a: assert property (@(posedge clock_i) disable iff (rst_i)
    nv_commit_o |-> $past(unlock_q) && !unlock_q)
    else $error("commit without clearing code word");
endmodule // cpi_channel
`default_nettype wire

// file: hw/cpi_image_port.sv
// Process image port: eight channels, complex or compact layout.
// Assumes the coupler images are flat byte vectors, byte 0 in bits 7:0,
// and are synchronous to clock_i.
// Operation
// - Complex image is 24 bytes each way
// - Channel is status byte plus data word
// - Compact image: eight words, no output
// - Output words only serve register access
// - Channels two to eight behave like one
// - Control bit 7 clear selects process mode
// - Control bit 5 activates calibration
// - Gain, offset, clock speed, up, down bits
// - Calibration needs unlock code in register 31
// - Clearing code word commits trim permanently
// - Control out, status in
// - Status bit 7 zero in process mode
// - Overrange bit 1, error bit 6
// - Underrange sets status bit 0
// - Bit 7 set selects register communication
`timescale 1ns/1ps
`default_nettype none
`include "cpi_defines.svh"
module cpi_image_port
  import cpi_pkg::*;
#(
  parameter int NUM_CH = `CPI_NUM_CH,
  parameter int SLOW_CYC = `CPI_SLOW_CYC,
  parameter int FAST_CYC = `CPI_FAST_CYC
) (
  input wire logic clock_i, // System clock
  input wire logic rst_i, // Async reset, high
  input wire logic compact_i, // 1 selects compact image
  input wire logic align_i, // 1 selects word-aligned image
  input wire logic [8*`CPI_IMAGE_BYTES-1:0] out_image_i, // Output image
  input wire logic [NUM_CH*16-1:0] sample_i, // Raw values
  input wire logic [NUM_CH-1:0] over_i, // Overrange per channel
  input wire logic [NUM_CH-1:0] under_i, // Underrange per channel
  input wire logic [NUM_CH-1:0] fault_i, // Fault per channel
  output logic [8*`CPI_IMAGE_BYTES-1:0] in_image_o, // Input image
  output logic [7:0] in_len_o, // Input image length, bytes
  output logic [7:0] out_len_o, // Output image length, bytes
  output logic [NUM_CH-1:0] nv_commit_o, // Trim store pulse
  output logic [NUM_CH*16-1:0] gain_trim_o, // Gain trims
  output logic [NUM_CH*16-1:0] offset_trim_o // Offset trims
);
  import cpi_pkg::*;

  // Room for the aligned layout; the unaligned one uses the first 24 bytes
  localparam int IMG_BITS = 8 * `CPI_IMAGE_BYTES;
  cpi_byte_t sb [NUM_CH];
  cpi_word_t dw [NUM_CH];
  cpi_byte_t cb [NUM_CH];
  cpi_word_t ow [NUM_CH];
  logic [IMG_BITS-1:0] img_d;

  // Byte address of a channel's status/control byte
  function automatic int ch_base(input int n, input logic aligned);
    return aligned ? n * `CPI_ALIGNED_STRIDE
      : n * `CPI_UNALIGNED_STRIDE;
  endfunction

  // Byte address of a channel's data word; aligned, a pad byte comes first
  function automatic int word_base(input int n, input logic aligned);
    return ch_base(n, aligned) + (aligned ? 2 : 1);
  endfunction

  // Compact mode receives nothing: controls forced to process mode
  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      int b;
      int w;
      b = ch_base(n, align_i);
      w = word_base(n, align_i);
      cb[n] = compact_i ? 8'h00 : out_image_i[8*b +: 8];
      ow[n] = compact_i ? 16'h0000
        : {out_image_i[8*(w+1) +: 8], out_image_i[8*w +: 8]};
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    cpi_channel #(
      .SLOW_CYC(SLOW_CYC),
      .FAST_CYC(FAST_CYC)
    ) u_ch (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .channel_control_byte_i(cb[g]),
      .channel_output_word_i(ow[g]),
      .sample_i(sample_i[16*g +: 16]),
      .over_i(over_i[g]),
      .under_i(under_i[g]),
      .fault_i(fault_i[g]),
      .channel_status_byte_o(sb[g]),
      .channel_input_word_o(dw[g]),
      .nv_commit_o(nv_commit_o[g]),
      .gain_trim_o(gain_trim_o[16*g +: 16]),
      .offset_trim_o(offset_trim_o[16*g +: 16])
    );
  end

  always_comb begin
    img_d = '0;
    for (int n = 0; n < NUM_CH; n++) begin
      int b;
      int w;
      b = ch_base(n, align_i);
      w = word_base(n, align_i);
      if (compact_i) begin
        img_d[16*n +: 16] = dw[n];
      end else begin
        img_d[8*b +: 8] = sb[n];
        img_d[8*w +: 16] = dw[n];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      in_image_o <= '0;
    end else begin
      in_image_o <= img_d;
    end
  end

  // Complex image length is 24 bytes, also where the aligned layout spans 32 bytes of coupler space
  assign in_len_o = compact_i ? 8'(`CPI_COMPACT_BYTES)
    : 8'(`CPI_COMPLEX_BYTES);
  assign out_len_o = compact_i ? 8'h00 : 8'(`CPI_COMPLEX_BYTES);

  compact_out_a: assert property (@(posedge clock_i) disable iff (rst_i)
    compact_i |-> out_len_o == 8'h00 && in_len_o == 8'h10)
    else $error("compact image length wrong");
  complex_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !compact_i |-> in_len_o == 8'h18 && out_len_o == 8'h18)
    else $error("complex image length wrong");

  // Compact image leaves every byte past the eight words at zero
  compact_tail_a: assert property (@(posedge clock_i) disable iff (rst_i)
    compact_i |=> in_image_o[IMG_BITS-1:8*`CPI_COMPACT_BYTES] == '0)
    else $error("compact image tail not zero");

  // Per channel: where the controls are read from and where each
  // registered byte lands one cycle later, for every layout
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    localparam int UB = g * `CPI_UNALIGNED_STRIDE;
    localparam int AB = g * `CPI_ALIGNED_STRIDE;
    localparam logic [7:0] CODE_CB = {2'b11, `CPI_UNLOCK_REG};
    localparam logic [7:0] READ_CB = {2'b10, `CPI_UNLOCK_REG};

    // A store takes two writes: the code word, then zero in its place
    sequence code_set_s;
      cb[g] == CODE_CB && ow[g] == `CPI_UNLOCK_CODE;
    endsequence
    sequence code_clear_s;
      cb[g] == CODE_CB && ow[g] == 16'h0000;
    endsequence
    sequence code_read_s;
      cb[g] == READ_CB;
    endsequence

    plain_ctl_a: assert property (@(posedge clock_i)
      disable iff (rst_i) !compact_i && !align_i
        |-> cb[g] == out_image_i[8*UB +: 8]
          && ow[g] == out_image_i[8*(UB+1) +: 16])
      else $error("unaligned control misread");
    even_ctl_a: assert property (@(posedge clock_i)
      disable iff (rst_i) !compact_i && align_i
        |-> cb[g] == out_image_i[8*AB +: 8]
          && ow[g] == out_image_i[8*(AB+2) +: 16])
      else $error("aligned control misread");
    compact_quiet_a: assert property (@(posedge clock_i)
      disable iff (rst_i) compact_i |-> cb[g] == 8'h00 && ow[g] == 16'h0000)
      else $error("compact image passed output data");

    plain_place_a: assert property (@(posedge clock_i)
      disable iff (rst_i) !compact_i && !align_i
        |=> in_image_o[8*UB +: 8] == $past(sb[g])
          && in_image_o[8*(UB+1) +: 16] == $past(dw[g]))
      else $error("unaligned channel misplaced");
    even_place_a: assert property (@(posedge clock_i)
      disable iff (rst_i) !compact_i && align_i
        |=> in_image_o[8*AB +: 8] == $past(sb[g])
          && in_image_o[8*(AB+1) +: 8] == 8'h00
          && in_image_o[8*(AB+2) +: 16] == $past(dw[g]))
      else $error("aligned channel misplaced");
    compact_place_a: assert property (@(posedge clock_i)
      disable iff (rst_i) compact_i
        |=> in_image_o[16*g +: 16] == $past(dw[g]))
      else $error("compact word misplaced");

    reg_echo_a: assert property (@(posedge clock_i)
      disable iff (rst_i) cb[g][`CPI_CB_REGACC]
        |=> sb[g] == {2'b10, $past(cb[g][5:0])})
      else $error("register access not echoed");
    proc_echo_a: assert property (@(posedge clock_i)
      disable iff (rst_i) !cb[g][`CPI_CB_REGACC]
        |=> !sb[g][`CPI_SB_REGACC])
      else $error("process mode not acknowledged");

    unlock_read_a: assert property (@(posedge clock_i)
      disable iff (rst_i) code_set_s ##1 code_read_s |=> dw[g] == 16'h0001)
      else $error("unlock state not read back");
    store_step_a: assert property (@(posedge clock_i)
      disable iff (rst_i) code_set_s ##1 code_clear_s |=> nv_commit_o[g])
      else $error("clearing code word did not store trim");
    commit_cause_a: assert property (@(posedge clock_i)
      disable iff (rst_i)
      nv_commit_o[g] |-> $past(cb[g] == CODE_CB && ow[g] == 16'h0000))
      else $error("trim stored without clearing code word");
    relock_trim_a: assert property (@(posedge clock_i)
      disable iff (rst_i) code_clear_s
        |=> ##1 $stable(gain_trim_o[16*g +: 16])
          && $stable(offset_trim_o[16*g +: 16]))
      else $error("trim moved after code word cleared");
    compact_commit_a: assert property (@(posedge clock_i)
      disable iff (rst_i) compact_i |=> !nv_commit_o[g])
      else $error("trim stored in compact image");
    compact_trim_a: assert property (@(posedge clock_i)
      disable iff (rst_i) compact_i |=> $stable(gain_trim_o[16*g +: 16])
        && $stable(offset_trim_o[16*g +: 16]))
      else $error("trim moved in compact image");
  end
endmodule // cpi_image_port
`default_nettype wire

// file: sim/cpi_coupler_model.sv
// Coupler side model: packs control bytes and output words into the image.
// Assumes the bench changes ctl_i and wrd_i just after rising edges.
`timescale 1ns/1ps
`default_nettype none
`include "cpi_defines.svh"
module cpi_coupler_model (
  input wire logic clock_i, // System clock
  input wire logic align_i, // 1 places values on even bytes
  input wire logic compact_i, // 1 sends no output data
  input wire logic [63:0] ctl_i, // Control bytes
  input wire logic [127:0] wrd_i, // Output words
  output logic [8*`CPI_IMAGE_BYTES-1:0] out_image_o // Output image
);
  logic [8*`CPI_IMAGE_BYTES-1:0] img_d, img_q;
  always_comb begin
    img_d = '0;
    for (int n = 0; n < 8; n++) begin
      int b;
      b = align_i ? 4 * n : 3 * n;
      img_d[8*b +: 8] = ctl_i[8*n +: 8];
      img_d[8*(b + 1 + int'(align_i)) +: 16] = wrd_i[16*n +: 16];
    end
    // No output data in compact: lines carry changing junk
    out_image_o = compact_i ? ~img_q : img_d;
  end
  always_ff @(posedge clock_i) img_q <= out_image_o;
endmodule // cpi_coupler_model
`default_nettype wire

// file: sim/tb.sv
// Bench for the process image port: random image traffic and calibration.
// Assumes short step counts of 4 and 2 cycles on the port.
`timescale 1ns/1ps
`default_nettype none
`include "cpi_defines.svh"
module tb;
  logic clock_i = 1'b0, rst_i = 1'b1, compact_i = 1'b0, align_i = 1'b0;
  logic [63:0] ctl = '0;
  logic [127:0] wrd = '0, sample = '0, gain, offs;
  logic [7:0] over = '0, under = '0, fault = '0, in_len, out_len, nvc;
  logic [8*`CPI_IMAGE_BYTES-1:0] out_image, in_image;
  logic [15:0] g0, o0;
  int fails = 0, checked = 0, r, hits;
  initial forever #5 clock_i = ~clock_i;
  cpi_coupler_model i_cpi_coupler_model (.clock_i(clock_i),
    .align_i(align_i), .compact_i(compact_i), .ctl_i(ctl), .wrd_i(wrd),
    .out_image_o(out_image));
  cpi_image_port #(.SLOW_CYC(4), .FAST_CYC(2)) i_cpi_image_port (
    .clock_i(clock_i), .rst_i(rst_i), .compact_i(compact_i),
    .align_i(align_i), .out_image_i(out_image), .sample_i(sample),
    .over_i(over), .under_i(under), .fault_i(fault),
    .in_image_o(in_image), .in_len_o(in_len), .out_len_o(out_len),
    .nv_commit_o(nvc), .gain_trim_o(gain), .offset_trim_o(offs));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] exp_sb(int n);
    if (ctl[8*n+7]) return {1'b1, 1'b0, ctl[8*n +: 6]};
    return {1'b0, fault[n] | over[n] | under[n], 4'h0, over[n], under[n]};
  endfunction
  // Register reads of the plain registers return zero
  function automatic logic [15:0] exp_word(int n);
    if (ctl[8*n+7] && !compact_i) return 16'h0;
    return sample[16*n +: 16];
  endfunction
  task automatic check_image();
    int b;
    logic [7:0] sb;
    check("in_len", 16'(in_len), compact_i ? 16'h10 : 16'h18);
    check("out_len", 16'(out_len), compact_i ? 16'h0 : 16'h18);
    for (int n = 0; n < 8; n++) begin
      b = compact_i ? 2 * n : (align_i ? 4 * n : 3 * n);
      if (!compact_i) begin
        sb = in_image[8*b +: 8];
        check("status", 16'(sb), 16'(exp_sb(n)));
        b = b + 1 + int'(align_i);
        if (align_i) check("pad", 16'(in_image[8*b-8 +: 8]), 16'h0);
      end
      check("word", in_image[8*b +: 16], exp_word(n));
    end
  endtask
  task automatic set_ch(input logic [7:0] c, input logic [15:0] w);
    @(posedge clock_i);
    ctl[23:16] <= c;
    wrd[47:32] <= w;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  initial begin
    void'($urandom(61578));
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (60) begin
      @(posedge clock_i);
      compact_i <= $urandom_range(0, 3) == 0;
      align_i <= 1'($urandom_range(0, 1));
      sample <= {$urandom, $urandom, $urandom, $urandom};
      over <= 8'($urandom);
      under <= 8'($urandom);
      fault <= 8'($urandom);
      for (int n = 0; n < 8; n++) begin
        r = $urandom_range(0, 30);
        // Write bit 6 stays clear; register reads skip the unlock register
        ctl[8*n +: 8] <= {1'($urandom_range(0, 1)), 1'b0, 6'(r)};
        wrd[16*n +: 16] <= 16'($urandom);
      end
      // Status and words pass two register stages before the image
      cyc(2);
      check_image();
      check("no commit", 16'(nvc), 16'h0);
    end
    check("locked trims", 16'(|{gain, offs}), 16'h0);
    @(posedge clock_i);
    compact_i <= 1'b0;
    align_i <= 1'b0;
    ctl <= '0;
    set_ch(8'hdf, `CPI_UNLOCK_CODE);
    cyc(2);
    check("unlock ack", 16'(in_image[55:48]), 16'h9f);
    set_ch(8'h9f, 16'h0);
    cyc(2);
    check("unlock read", in_image[71:56], 16'h1);
    set_ch(8'h36, 16'h0);
    cyc(10);
    g0 = gain[47:32];
    check("gain fast", 16'(g0 >= 4 && g0 <= 6), 16'h1);
    set_ch(8'h16, 16'h0);
    cyc(10);
    check("gain held", gain[47:32], g0);
    set_ch(8'h35, 16'h0);
    cyc(4);
    check("gain down", 16'(gain[47:32] < g0), 16'h1);
    g0 = gain[47:32];
    set_ch(8'h2a, 16'h0);
    cyc(16);
    o0 = offs[47:32];
    check("offset slow", 16'(o0 >= 3 && o0 <= 5), 16'h1);
    check("gain kept", gain[47:32], g0);
    set_ch(8'hdf, 16'h0);
    hits = 0;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      if (nvc === 8'h04) hits++;
      else check("other commit", 16'(nvc), 16'h0);
    end
    check("commit pulses", 16'(hits), 16'h1);
    set_ch(8'h36, 16'h0);
    cyc(10);
    check("relocked", gain[47:32], g0);
    // Code word and its clearing back to back store at once
    set_ch(8'hdf, `CPI_UNLOCK_CODE);
    set_ch(8'hdf, 16'h0);
    cyc(1);
    check("quick commit", 16'(nvc), 16'h04);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
